// ---- pin_select_pkg.sv ----
package pin_select_pkg;

  // ------------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------------
  localparam int DATA_W    = 16;  // Register data width
  localparam int ADDR_W    = 6;   // Register word address width
  localparam int SEL_W     = 6;   // One selection field
  localparam int IN_FIELDS = 48;  // Peripheral inputs, two per input register
  localparam int IO_PINS   = 32;  // Bidirectional remappable pins
  localparam int INO_PINS  = 12;  // Input-only remappable pins
  localparam int ALL_PINS  = 44;  // Pin codes 0..43
  localparam int OUT_FUNCS = 32;  // Output function codes 0..31

  // ------------------------------------------------------------------
  // Register map (word addresses)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IN_END   = 6'h18;  // Input registers 0x00..0x17
  localparam logic [ADDR_W-1:0] OUT_BASE = 6'h20;  // Output registers 0x20..0x2F
  localparam logic [ADDR_W-1:0] OUT_END  = 6'h30;
  localparam logic [ADDR_W-1:0] OSC_ADDR = 6'h30;  // Oscillator control low byte

  // ------------------------------------------------------------------
  // Field layout, keys and reset values
  // ------------------------------------------------------------------
  localparam int LO_LSB   = 0;   // Low field position
  localparam int HI_LSB   = 8;   // High field position
  localparam int LOCK_BIT = 6;   // Mapping lock in oscillator control
  localparam logic [7:0]       KEY_FIRST_VAL  = 8'h46;
  localparam logic [7:0]       KEY_SECOND_VAL = 8'h57;
  localparam logic [SEL_W-1:0] IN_RESET       = 6'h3F;  // Tied to ground
  localparam logic [SEL_W-1:0] OUT_RESET      = 6'h00;  // Null output
  localparam logic [SEL_W-1:0] PIN_LIMIT      = 6'h2C;  // First code past pin 43

  // ------------------------------------------------------------------
  // Package variants and their implemented pins
  // ------------------------------------------------------------------
  localparam logic [1:0]          VARIANT_LARGE = 2'h0;
  localparam logic [1:0]          VARIANT_64    = 2'h1;
  localparam logic [1:0]          VARIANT_USB   = 2'h2;
  localparam logic [IO_PINS-1:0]  IO_MASK_LARGE = 32'hFFFFFFFF;
  localparam logic [IO_PINS-1:0]  IO_MASK_64    = 32'h7FFF7FDF;  // Less 5, 15, 31
  localparam logic [IO_PINS-1:0]  IO_MASK_USB   = 32'h3FFF7FDF;  // Less 5, 15, 30, 31
  localparam logic [INO_PINS-1:0] INO_MASK_ALL  = 12'hFFF;
  localparam logic [INO_PINS-1:0] INO_MASK_ONE  = 12'h020;       // Only pin 37

  // Unlock sequence states
  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_FIRST = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_type;

endpackage

// ---- pin_select_fabric.sv ----
// Function
// - Fabric structure prevents input and output contention
// - One pin may feed many; fan-out allowed
// - Input codes span 64, outputs 32 pins
// - Large variant 32+12 pins, 64-pin 29+1
// - USB variant 28 pins, input only 37
// - Absent pin input code feeds nothing
// - Absent pin output fields ignore writes
// - Locked mapping writes leave contents unchanged
// - Lock is oscillator control bit six
// - Keys 46h then 57h precede lock change
// - Lock holds until changed again
// - Shadow copies flag mismatch reset; here a mismatch only raises configMismatch, no reset is made
// - One-way configuration forbids clearing lock again
// - One-way bit defaults set, one session
// - Reset: inputs ground, outputs disconnected
// - Lock resets unlocked
// - Mapping never enables peripherals or pins; here a mapped output drives pinOeN low
// - Analog pins keep selected input disconnected
// - Input selection is six-bit pin number
// - Output register holds two six-bit fields
//
// Local design decisions: the plain strobed port and the address map.
module pin_select_fabric (
  input  wire logic                                      clock,
  input  wire logic                                      sys_rst,
  input  wire logic [pin_select_pkg::ADDR_W-1:0]         address,
  input  wire logic [pin_select_pkg::DATA_W-1:0]         writeData,
  input  wire logic                                      writeStrobe,
  input  wire logic                                      readStrobe,
  output logic      [pin_select_pkg::DATA_W-1:0]         readData,
  input  wire logic                                      oneShotLockConfig,
  input  wire logic [1:0]                                variantSelect,
  input  wire logic [pin_select_pkg::ALL_PINS-1:0]       pinIn,
  input  wire logic [pin_select_pkg::ALL_PINS-1:0]       analogEnable,
  input  wire logic [pin_select_pkg::OUT_FUNCS-1:0]      periphOutFn,
  output logic      [pin_select_pkg::IN_FIELDS-1:0]      periphIn,
  output logic      [pin_select_pkg::IO_PINS-1:0]        pinOut,
  output logic      [pin_select_pkg::IO_PINS-1:0]        pinOeN,
  output logic                                           pinMapLock,
  output logic                                           configMismatch
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [pin_select_pkg::SEL_W-1:0]    inputSelect [pin_select_pkg::IN_FIELDS]; // Live
  logic [pin_select_pkg::SEL_W-1:0]    inputShadow [pin_select_pkg::IN_FIELDS]; // Copy
  logic [pin_select_pkg::SEL_W-1:0]    outputMap   [pin_select_pkg::IO_PINS];   // Live
  logic [pin_select_pkg::SEL_W-1:0]    outputShadow[pin_select_pkg::IO_PINS];   // Copy
  logic [pin_select_pkg::ALL_PINS-1:0] pinMeta;        // First sync stage
  logic [pin_select_pkg::ALL_PINS-1:0] pinSync;        // Second sync stage
  logic                                strapTaken;     // Straps caught
  logic                                oneWay;         // Captured one-way bit
  logic [1:0]                          variant;        // Captured variant
  logic                                lockSetOnce;    // Lock has been set
  pin_select_pkg::key_state_type       keyState;       // Unlock sequence
  pin_select_pkg::key_state_type       next_keyState;
  logic [pin_select_pkg::IO_PINS-1:0]  ioMask;         // Implemented I/O pins
  logic [pin_select_pkg::INO_PINS-1:0] inoMask;        // Implemented input pins
  logic [pin_select_pkg::ALL_PINS-1:0] pinPresent;     // All implemented pins
  logic                                inHit;          // Input register access
  logic                                outHit;         // Output register access
  logic                                oscHit;         // Control register access
  logic                                mapWrite;       // Unlocked mapping write
  logic                                oscWrite;       // Control register write
  logic                                anyAccess;      // Any bus strobe
  logic [4:0]                          inIdx;          // Input register index
  logic [3:0]                          outIdx;         // Output register index
  logic                                mismatchNow;    // Shadow disagreement
  logic [pin_select_pkg::DATA_W-1:0]   next_readData;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  always_comb begin
    inHit     = (address < pin_select_pkg::IN_END);
    outHit    = (address >= pin_select_pkg::OUT_BASE) && (address < pin_select_pkg::OUT_END);
    oscHit    = (address == pin_select_pkg::OSC_ADDR);
    inIdx     = address[4:0];
    outIdx    = address[3:0];
    anyAccess = writeStrobe || readStrobe;
    oscWrite  = writeStrobe && oscHit;
    mapWrite  = writeStrobe && !pinMapLock && (inHit || outHit);
  end

  // ------------------------------------------------------------------
  // Strap capture after reset release
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strapTaken <= 1'b0;
      oneWay     <= 1'b1;  // Unprogrammed default: one session
      variant    <= pin_select_pkg::VARIANT_LARGE;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      oneWay     <= oneShotLockConfig;
      variant    <= variantSelect;
    end
  end

  // ------------------------------------------------------------------
  // Variant pin masks
  // ------------------------------------------------------------------
  always_comb begin
    case (variant)
      pin_select_pkg::VARIANT_LARGE: begin
        ioMask  = pin_select_pkg::IO_MASK_LARGE;
        inoMask = pin_select_pkg::INO_MASK_ALL;
      end
      pin_select_pkg::VARIANT_64: begin
        ioMask  = pin_select_pkg::IO_MASK_64;
        inoMask = pin_select_pkg::INO_MASK_ONE;
      end
      default: begin
        ioMask  = pin_select_pkg::IO_MASK_USB;
        inoMask = pin_select_pkg::INO_MASK_ONE;
      end
    endcase
    pinPresent = {inoMask, ioMask};
  end

  // ------------------------------------------------------------------
  // Unlock key sequence
  // ------------------------------------------------------------------
  always_comb begin
    next_keyState = keyState;
    case (keyState)
      pin_select_pkg::KEY_IDLE: begin
        if (oscWrite && writeData[7:0] == pin_select_pkg::KEY_FIRST_VAL) begin
          next_keyState = pin_select_pkg::KEY_FIRST;
        end
      end
      pin_select_pkg::KEY_FIRST: begin
        // Second key must be the very next access
        if (oscWrite && writeData[7:0] == pin_select_pkg::KEY_SECOND_VAL) begin
          next_keyState = pin_select_pkg::KEY_ARMED;
        end else if (oscWrite && writeData[7:0] == pin_select_pkg::KEY_FIRST_VAL) begin
          next_keyState = pin_select_pkg::KEY_FIRST;
        end else if (anyAccess) begin
          next_keyState = pin_select_pkg::KEY_IDLE;
        end
      end
      pin_select_pkg::KEY_ARMED: begin
        // Armed for exactly one following access
        if (anyAccess) begin
          next_keyState = pin_select_pkg::KEY_IDLE;
        end
      end
      default: begin
        next_keyState = pin_select_pkg::KEY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      keyState <= pin_select_pkg::KEY_IDLE;
    end else begin
      keyState <= next_keyState;
    end
  end

  // ------------------------------------------------------------------
  // Mapping lock
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinMapLock  <= 1'b0;
      lockSetOnce <= 1'b0;
    end else if (oscWrite && keyState == pin_select_pkg::KEY_ARMED) begin
      if (writeData[pin_select_pkg::LOCK_BIT]) begin
        pinMapLock  <= 1'b1;
        lockSetOnce <= 1'b1;
      end else if (!(oneWay && lockSetOnce)) begin
        pinMapLock  <= 1'b0;
      end
    end
    // Otherwise the lock keeps its value
  end

  // ------------------------------------------------------------------
  // Mapping registers and their shadow copies
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int f = 0; f < pin_select_pkg::IN_FIELDS; f++) begin
        inputSelect[f] <= pin_select_pkg::IN_RESET;
        inputShadow[f] <= pin_select_pkg::IN_RESET;
      end
      for (int p = 0; p < pin_select_pkg::IO_PINS; p++) begin
        outputMap[p]    <= pin_select_pkg::OUT_RESET;
        outputShadow[p] <= pin_select_pkg::OUT_RESET;
      end
    end else if (mapWrite) begin
      if (inHit) begin
        inputSelect[{inIdx, 1'b0}] <= writeData[pin_select_pkg::LO_LSB +: pin_select_pkg::SEL_W];
        inputSelect[{inIdx, 1'b1}] <= writeData[pin_select_pkg::HI_LSB +: pin_select_pkg::SEL_W];
        inputShadow[{inIdx, 1'b0}] <= writeData[pin_select_pkg::LO_LSB +: pin_select_pkg::SEL_W];
        inputShadow[{inIdx, 1'b1}] <= writeData[pin_select_pkg::HI_LSB +: pin_select_pkg::SEL_W];
      end
      if (outHit) begin
        // Fields of absent pins stay at the null code
        if (ioMask[{outIdx, 1'b0}]) begin
          outputMap[{outIdx, 1'b0}] <= writeData[pin_select_pkg::LO_LSB +: pin_select_pkg::SEL_W];
          outputShadow[{outIdx, 1'b0}] <= writeData[pin_select_pkg::LO_LSB +: pin_select_pkg::SEL_W];
        end
        if (ioMask[{outIdx, 1'b1}]) begin
          outputMap[{outIdx, 1'b1}] <= writeData[pin_select_pkg::HI_LSB +: pin_select_pkg::SEL_W];
          outputShadow[{outIdx, 1'b1}] <= writeData[pin_select_pkg::HI_LSB +: pin_select_pkg::SEL_W];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Continuous shadow compare
  // ------------------------------------------------------------------
  always_comb begin
    mismatchNow = 1'b0;
    for (int f = 0; f < pin_select_pkg::IN_FIELDS; f++) begin
      mismatchNow = mismatchNow || (inputSelect[f] != inputShadow[f]);
    end
    for (int p = 0; p < pin_select_pkg::IO_PINS; p++) begin
      mismatchNow = mismatchNow || (outputMap[p] != outputShadow[p]);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      configMismatch <= 1'b0;
    end else begin
      configMismatch <= mismatchNow;
    end
  end

  // ------------------------------------------------------------------
  // Pin input synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // ------------------------------------------------------------------
  // Input routing: each peripheral input names one pin, so two pins
  // can never drive one input; one pin may serve many inputs
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      periphIn <= '0;
    end else begin
      for (int f = 0; f < pin_select_pkg::IN_FIELDS; f++) begin
        if (inputSelect[f] < pin_select_pkg::PIN_LIMIT && pinPresent[inputSelect[f]]) begin
          periphIn[f] <= pinSync[inputSelect[f]] && !analogEnable[inputSelect[f]];
        end else begin
          periphIn[f] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Output routing: each pin names one function; a function may reach
  // many pins; only pin drive is touched, no peripheral is enabled
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= '0;
      pinOeN <= '1;
    end else begin
      for (int p = 0; p < pin_select_pkg::IO_PINS; p++) begin
        if (outputMap[p] != pin_select_pkg::OUT_RESET && !outputMap[p][5]) begin
          pinOut[p] <= periphOutFn[outputMap[p][4:0]];
          pinOeN[p] <= 1'b0;
        end else begin
          pinOut[p] <= 1'b0;
          pinOeN[p] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    next_readData = '0;
    if (readStrobe && inHit) begin
      next_readData[pin_select_pkg::LO_LSB +: pin_select_pkg::SEL_W] = inputSelect[{inIdx, 1'b0}];
      next_readData[pin_select_pkg::HI_LSB +: pin_select_pkg::SEL_W] = inputSelect[{inIdx, 1'b1}];
    end else if (readStrobe && outHit) begin
      next_readData[pin_select_pkg::LO_LSB +: pin_select_pkg::SEL_W] = outputMap[{outIdx, 1'b0}];
      next_readData[pin_select_pkg::HI_LSB +: pin_select_pkg::SEL_W] = outputMap[{outIdx, 1'b1}];
    end else if (readStrobe && oscHit) begin
      next_readData[pin_select_pkg::LOCK_BIT] = pinMapLock;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readData <= '0;
    end else begin
      readData <= next_readData;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Later key steps each follow one idle bus cycle
  sequence keyOne;
    oscWrite && writeData[7:0] == pin_select_pkg::KEY_FIRST_VAL;
  endsequence
  sequence keyTwo;
    !anyAccess ##1 oscWrite && writeData[7:0] == pin_select_pkg::KEY_SECOND_VAL;
  endsequence
  sequence unlockWrite;
    !anyAccess ##1 oscWrite && !writeData[pin_select_pkg::LOCK_BIT] && !(oneWay && lockSetOnce);
  endsequence

  lock_hold_a: assert property (
    !(oscWrite && keyState == pin_select_pkg::KEY_ARMED) |=> $stable(pinMapLock))
    else $error("Lock changed without an armed write");

  unlock_seq_a: assert property (
    (keyState != pin_select_pkg::KEY_ARMED) ##0 keyOne ##1 keyTwo ##1 unlockWrite
    |=> !pinMapLock)
    else $error("Valid key sequence did not clear the lock");

  broken_seq_a: assert property (
    keyOne ##1 !anyAccess ##1 (anyAccess && !oscWrite) ##1 keyTwo ##1 !anyAccess ##1 oscWrite
    |=> $stable(pinMapLock))
    else $error("Broken key pair still changed the lock");

  one_way_a: assert property (
    (oneWay && lockSetOnce) |-> pinMapLock)
    else $error("One-way lock was cleared");

  locked_write_a: assert property ((writeStrobe && inHit && inIdx == '0 && pinMapLock)
    |=> $stable(inputSelect[0]) && $stable(inputSelect[1]))
    else $error("Locked write changed an input selection");

  absent_out_a: assert property (
    !ioMask[5] |-> outputMap[5] == pin_select_pkg::OUT_RESET)
    else $error("Absent pin output field holds a code");

  invalid_in_a: assert property (
    (inputSelect[0] >= pin_select_pkg::PIN_LIMIT) |=> !periphIn[0])
    else $error("Invalid input code fed a pin");

  null_out_a: assert property (
    (outputMap[0] == pin_select_pkg::OUT_RESET) ##1 1'b1 |-> pinOeN[0])
    else $error("Null output code drove a pin");

  shadow_a: assert property (
    $rose(mismatchNow) |=> configMismatch ##1 (configMismatch || !$past(mismatchNow)))
    else $error("Shadow mismatch not flagged");

endmodule

// ---- pin_side_model.sv ----
// ------------------------------------------------------------------
// Pads and peripherals seen from the pin select fabric
// ------------------------------------------------------------------
module pin_side_model (
  input  wire logic [43:0] pinDrive,
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOeN,
  output logic      [43:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // A driven I/O pad reads back its own output, else the board level
  assign pinIn = {pinDrive[43:32], (~pinOeN & pinOut) | (pinOeN & pinDrive[31:0])};
endmodule

// ---- tb_top.sv ----
// ------------------------------------------------------------------
// Self-checking bench for the pin select fabric
// ------------------------------------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;              // 20 MHz system clock
  logic        sys_rst = 1'b1;            // Asynchronous reset
  logic [5:0]  address = 6'h00;           // Register bus
  logic [15:0] writeData = 16'h0000;
  logic        writeStrobe = 1'b0;
  logic        readStrobe = 1'b0;
  logic [15:0] readData;
  logic        oneShotLockConfig = 1'b1;  // Strap
  logic [1:0]  variantSelect = 2'h0;      // Strap
  logic [43:0] pinDrive = 44'h0;          // Board levels
  logic [43:0] pinIn;
  logic [43:0] analogEnable = 44'h0;
  logic [31:0] periphOutFn = 32'h0;
  logic [47:0] periphIn;
  logic [31:0] pinOut;
  logic [31:0] pinOeN;
  logic        pinMapLock;
  logic        configMismatch;
  int          miscompares = 0;
  int          n_checks = 0;

  always #25 clock = ~clock;

  pin_select_fabric i_pin_select_fabric (.clock(clock), .sys_rst(sys_rst), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .oneShotLockConfig(oneShotLockConfig),
    .variantSelect(variantSelect), .pinIn(pinIn), .analogEnable(analogEnable),
    .periphOutFn(periphOutFn), .periphIn(periphIn), .pinOut(pinOut), .pinOeN(pinOeN),
    .pinMapLock(pinMapLock), .configMismatch(configMismatch));

  pin_side_model i_pin_side_model (.pinDrive(pinDrive), .pinOut(pinOut), .pinOeN(pinOeN),
    .pinIn(pinIn));

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rc(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    chk(readData, exp);
  endtask

  // Key pair then lock write; brk slips a read between the keys
  task automatic lk(input logic [15:0] v, input bit brk);
    wr(6'h30, 16'h0046);
    if (brk) begin
      rc(6'h3F, 16'h0000);
    end
    wr(6'h30, 16'h0057);
    wr(6'h30, v);
    @(posedge clock);
    #1;
  endtask

  // Straps held over the capture edge; first request two edges after release
  task automatic rst(input logic [1:0] v, input logic o);
    @(posedge clock);
    sys_rst <= 1'b1;
    variantSelect <= v;
    oneShotLockConfig <= o;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rc(6'h00, 16'h3F3F);
    rc(6'h20, 16'h0000);
    chk(pinOeN[15:0], 16'hFFFF);
    chk({15'h0, pinMapLock}, 16'h0000);
    rc(6'h3F, 16'h0000);
    chk({15'h0, configMismatch}, 16'h0000);
  endtask

  task automatic t_input;
    wr(6'h00, 16'h0303);
    pinDrive[3] <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk({14'h0, periphIn[1:0]}, 16'h0003);
    @(posedge clock);
    analogEnable[3] <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk({15'h0, periphIn[0]}, 16'h0000);
    @(posedge clock);
    analogEnable[3] <= 1'b0;
    wr(6'h00, 16'h3232);
    repeat (3) @(posedge clock);
    #1;
    chk({14'h0, periphIn[1:0]}, 16'h0000);
    rc(6'h00, 16'h3232);
  endtask

  task automatic t_output;
    @(posedge clock);
    periphOutFn <= 32'h0000_0008;
    wr(6'h20, 16'h0403);
    wr(6'h21, 16'h0003);
    @(posedge clock);
    #1;
    chk({13'h0, pinOeN[2:0]}, 16'h0000);
    chk({13'h0, pinOut[2:0]}, 16'h0005);
    chk({15'h0, pinOeN[3]}, 16'h0001);
    wr(6'h21, 16'h0000);
    @(posedge clock);
    #1;
    chk({15'h0, pinOeN[2]}, 16'h0001);
  endtask

  task automatic t_lock_one_way;
    lk(16'h0040, 1'b0);
    chk({15'h0, pinMapLock}, 16'h0001);
    rc(6'h30, 16'h0040);
    wr(6'h00, 16'h0000);
    rc(6'h00, 16'h3232);
    repeat (20) @(posedge clock);
    lk(16'h0000, 1'b0);
    chk({15'h0, pinMapLock}, 16'h0001);
  endtask

  task automatic t_lock_sessions;
    wr(6'h30, 16'h0040);
    #1;
    chk({15'h0, pinMapLock}, 16'h0000);
    lk(16'h0040, 1'b1);
    chk({15'h0, pinMapLock}, 16'h0000);
    lk(16'h0040, 1'b0);
    lk(16'h0000, 1'b0);
    chk({15'h0, pinMapLock}, 16'h0000);
    wr(6'h01, 16'h0505);
    repeat (20) @(posedge clock);
    rc(6'h01, 16'h0505);
  endtask

  // Mid-size package: pins 5, 15, 31 and all input-only pins but 37 absent
  task automatic t_variant_64;
    wr(6'h2F, 16'h0303);
    rc(6'h2F, 16'h0003);
    wr(6'h01, 16'h2520);
    pinDrive[37:32] <= 6'h21;
    repeat (4) @(posedge clock);
    #1;
    chk({14'h0, periphIn[3:2]}, 16'h0002);
  endtask

  task automatic t_variant_usb;
    wr(6'h22, 16'h0303);
    rc(6'h22, 16'h0003);
    wr(6'h2F, 16'h0303);
    rc(6'h2F, 16'h0000);
    wr(6'h00, 16'h2521);
    pinDrive[37:33] <= 5'h11;
    repeat (4) @(posedge clock);
    #1;
    chk({14'h0, periphIn[1:0]}, 16'h0002);
  endtask

  // ------------------------------------------------------------------
  // Verdict and run order
  // ------------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #(50 * 5000);
    miscompares++;
    conclude();
  end

  initial begin
    rst(2'h0, 1'b1);
    t_reset();
    t_input();
    t_output();
    t_lock_one_way();
    rst(2'h0, 1'b0);
    t_lock_sessions();
    rst(2'h1, 1'b1);
    t_variant_64();
    rst(2'h2, 1'b1);
    t_variant_usb();
    conclude();
  end
endmodule
